// *** hw/qsf_buf2.sv ***
`timescale 1ns/100ps
module qsf_buf2
  import qsf_pkg::*;
(
  input  wire logic             i_clk,
  input  wire logic             i_rst_b,
  input  wire logic             i_flush,
  input  wire logic             i_valid,
  input  wire logic [BUF_W-1:0] i_data,
  output logic                  o_ready,
  output logic                  o_valid,
  output logic      [BUF_W-1:0] o_data,
  input  wire logic             i_ready
);

  logic [BUF_W-1:0] mem_q [BUF_DEPTH];
  logic             wr_ptr_q;
  logic             rd_ptr_q;
  logic [1:0]       count_q;
  logic [1:0]       count_d;
  logic             push;
  logic             pop;

  // Handshakes on each side; full and empty come from the count
  assign push    = i_valid & (count_q != 2'd2) & ~i_flush;
  assign pop     = i_ready & (count_q != 2'd0) & ~i_flush;
  assign count_d = count_q + {1'b0, push} - {1'b0, pop};
  assign o_ready = (count_q != 2'd2);
  assign o_valid = (count_q != 2'd0);
  assign o_data  = mem_q[rd_ptr_q];

  // Pointer and count update
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      count_q  <= 2'd0;
    end else if (i_flush) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      count_q  <= 2'd0;
    end else begin
      wr_ptr_q <= wr_ptr_q ^ push;
      rd_ptr_q <= rd_ptr_q ^ pop;
      count_q  <= count_d;
    end
  end

  // Storage
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= i_data;
    end
  end

endmodule // qsf_buf2

// *** hw/qsf_pkg.sv ***
package qsf_pkg;

  // Opcodes handled by the read path
  localparam logic [7:0] OP_QUAD_EXIT   = 8'hff;
  localparam logic [7:0] OP_QUAD_ENTRY  = 8'h38;
  localparam logic [7:0] OP_FAST_READ   = 8'h0b;
  localparam logic [7:0] OP_QUAD_OUT_RD = 8'h6b;
  localparam logic [7:0] OP_QUAD_IO_RD  = 8'heb;
  localparam logic [7:0] OP_SET_BURST   = 8'hc0;
  localparam logic [7:0] OP_WRAP_READ   = 8'h0c;

  // Mode byte upper nibble that keeps continuous-read mode
  localparam logic [3:0] MODE_CONT_NIB  = 4'ha;
  // Address byte that cancels continuous-read mode
  localparam logic [7:0] CONT_EXIT_BYTE = 8'hff;
  // Byte shown for read-locked blocks
  localparam logic [7:0] LOCKED_BYTE    = 8'h00;

  // Phase lengths in serial clocks
  localparam logic [4:0] CLKS_BYTE_X1   = 5'd8;
  localparam logic [4:0] CLKS_BYTE_X4   = 5'd2;
  localparam logic [4:0] CLKS_ADDR_X1   = 5'd24;
  localparam logic [4:0] CLKS_ADDR_X4   = 5'd6;
  localparam logic [4:0] CLKS_DUMMY_X1  = 5'd8;
  localparam logic [4:0] CLKS_DUMMY_FR4 = 5'd4;
  localparam logic [4:0] CLKS_DUMMY_QIO = 5'd4;
  localparam logic [4:0] CLKS_DUMMY_WR  = 5'd6;

  // Burst length field and its reset value (8 bytes)
  localparam int         BURST_W        = 2;
  localparam logic [1:0] BURST_RST      = 2'h0;
  localparam logic [5:0] BURST_BASE     = 6'h07;

  localparam int         ADDR_W         = 24;
  localparam logic [23:0] ADDR_RST      = 24'h000000;
  localparam int         BUF_W          = 9;
  localparam int         BUF_DEPTH      = 2;

  typedef enum logic [2:0] {
    ST_IDLE, ST_CMD, ST_ADDR, ST_MODE, ST_DUMMY, ST_BLEN, ST_DATA, ST_IGNORE
  } qsf_state_t;

endpackage

// *** hw/qsf_read_path.sv ***
`timescale 1ns/100ps
// Summary of operation
// - Opcode FFH leaves four-bit mode or continuous mode, in either width.
// - In continuous four-bit reads, first FFH clears continuous only; second leaves quad.
// - Single-bit mode ignores upper three data lines during opcode.
// - Power-up in single-bit mode; 0BH accepted in both modes.
// - After dummies, data driven on falling serial clock from given address.
// - Linear reads increment per byte, rolling over to 000000H.
// - Read-locked bytes are output as 00H.
// - Mode byte AXH: next transaction omits opcode, sends address, mode, dummies.
// - Any other mode byte: next transaction starts with a full opcode.
// - 6BH: single-line opcode, address, dummy byte; data on four lines.
// - EBH: single-line opcode, then four-bit address, mode, two dummy bytes.
// - EBH continuous: later transaction is address, mode and dummies only.
// - Burst code byte 00H..03H selects 8, 16, 32, 64 bytes; other codes leave it unchanged.
// - Burst length is 8 bytes after reset.
// - Wrapped read wraps inside aligned window of burst length.
// - Opcode 38H enters four-bit mode until reset or FFH.
module qsf_read_path
  import qsf_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_rst_b,
  input  wire logic              i_sck,
  input  wire logic              i_cs_b,
  input  wire logic [3:0]        i_serial_data_lines,
  output logic      [3:0]        o_serial_data_lines,
  output logic      [3:0]        o_serial_data_lines_oe,
  input  wire logic              i_quad_io_enable_bit,
  output logic      [ADDR_W-1:0] o_rd_addr,
  output logic                   o_rd_en,
  input  wire logic              i_rd_valid,
  input  wire logic [7:0]        i_rd_data,
  input  wire logic              i_rd_locked,
  output logic                   o_rd_ready,
  output logic                   o_quad_mode,
  output logic                   o_cont_mode,
  output logic      [BURST_W-1:0] o_burst_len
);

  // Next read address, linear or wrapped in the burst window
  function automatic logic [ADDR_W-1:0] next_addr(input logic [ADDR_W-1:0] a,
                                                  input logic wrap,
                                                  input logic [BURST_W-1:0] bl);
    logic [ADDR_W-1:0] mask;
    logic [ADDR_W-1:0] inc;
    mask = {18'h0, (BURST_BASE << bl) | BURST_BASE};
    inc  = a + 24'h000001;
    if (wrap) begin
      next_addr = (a & ~mask) | (inc & mask);
    end else begin
      next_addr = inc;
    end
  endfunction

  // Two-flop synchronisers for pins, plus a third stage for edges
  logic [5:0] sync1_q;
  logic [5:0] sync2_q;
  logic       sck_d3_q;
  logic       cs_d3_q;
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sync1_q  <= 6'h01; // Idle pins: select high, clock low
      sync2_q  <= 6'h01;
      sck_d3_q <= 1'b0;
      cs_d3_q  <= 1'b1;
    end else begin
      sync1_q  <= {i_serial_data_lines, i_sck, i_cs_b};
      sync2_q  <= sync1_q;
      sck_d3_q <= sync2_q[1];
      cs_d3_q  <= sync2_q[0];
    end
  end

  logic       cs_b_s;
  logic       sck_s;
  logic [3:0] sio_s;
  logic       sck_rise;
  logic       sck_fall;
  logic       cs_fall;
  logic       cs_rise;
  assign cs_b_s   = sync2_q[0];
  assign sck_s    = sync2_q[1];
  assign sio_s    = sync2_q[5:2];
  assign sck_rise = sck_s & ~sck_d3_q & ~cs_b_s;
  assign sck_fall = ~sck_s & sck_d3_q & ~cs_b_s;
  assign cs_fall  = ~cs_b_s & cs_d3_q;
  assign cs_rise  = cs_b_s & ~cs_d3_q;

  // Protocol state
  qsf_state_t        state_q;
  qsf_state_t        state_d;
  logic [7:0]        cmd_q;
  logic [31:0]       sh_q;
  logic [4:0]        cnt_q;
  logic              quad_q;
  logic              cont_q;
  logic              cont_txn_q;
  logic              ff_seen_q;
  logic [BURST_W-1:0] burst_q;
  logic [ADDR_W-1:0] addr_q;
  logic              rd_en_q;
  logic [7:0]        out_q;
  logic [2:0]        out_cnt_q;
  logic [3:0]        sio_out_q;
  logic [3:0]        sio_oe_q;
  logic              rd_ready_q;

  // Command attributes
  logic       is_qio;
  logic       addr_x4;
  logic       has_mode;
  logic       data_x4;
  logic       wrap;
  logic       in_x4;
  logic [4:0] dummy_clks;
  logic [4:0] phase_len;
  logic       phase_last;
  logic [31:0] sh_next;
  logic [7:0] in_byte;
  assign is_qio   = (cmd_q == OP_QUAD_IO_RD);
  assign addr_x4  = quad_q | is_qio;
  assign has_mode = is_qio | (quad_q & (cmd_q == OP_FAST_READ));
  assign data_x4  = quad_q | is_qio | (cmd_q == OP_QUAD_OUT_RD);
  assign wrap     = (cmd_q == OP_WRAP_READ);
  assign in_x4    = (state_q == ST_ADDR || state_q == ST_MODE) ? addr_x4 : quad_q;
  assign dummy_clks = wrap ? CLKS_DUMMY_WR :
                      is_qio ? CLKS_DUMMY_QIO :
                      (quad_q & (cmd_q == OP_FAST_READ)) ? CLKS_DUMMY_FR4 :
                      CLKS_DUMMY_X1;
  assign phase_len = (state_q == ST_ADDR) ? (addr_x4 ? CLKS_ADDR_X4 : CLKS_ADDR_X1) :
                     (state_q == ST_MODE) ? CLKS_BYTE_X4 :
                     (state_q == ST_DUMMY) ? dummy_clks :
                     (quad_q ? CLKS_BYTE_X4 : CLKS_BYTE_X1);
  assign phase_last = (cnt_q == phase_len - 5'd1);
  // Single-bit phases look only at line 0
  assign sh_next  = in_x4 ? {sh_q[27:0], sio_s} : {sh_q[30:0], sio_s[0]};
  assign in_byte  = sh_next[7:0];

  // Buffer between array and serialiser
  logic            buf_valid;
  logic [BUF_W-1:0] buf_data;
  logic            buf_in_ready;
  logic            buf_pop;
  logic            buf_push;
  logic            flush;
  assign flush    = cs_rise | cs_fall;
  assign buf_pop  = sck_fall & (state_q == ST_DATA) & (out_cnt_q == 3'd0);
  assign buf_push = i_rd_valid & buf_in_ready & rd_ready_q & rd_en_q; // Same as array accept

  qsf_buf2 u_buf (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_flush (flush),
    .i_valid (buf_push),
    .i_data  ({i_rd_locked, i_rd_data}),
    .o_ready (buf_in_ready),
    .o_valid (buf_valid),
    .o_data  (buf_data),
    .i_ready (buf_pop)
  );

  // Byte leaving the buffer, locked blocks read as zero
  logic [7:0] pop_byte;
  assign pop_byte = (!buf_valid || buf_data[8]) ? LOCKED_BYTE : buf_data[7:0];

  // Next state on serial clock rise and select edges
  always_comb begin
    state_d = state_q;
    if (cs_rise) begin
      state_d = ST_IDLE;
    end else if (cs_fall) begin
      state_d = cont_q ? ST_ADDR : ST_CMD;
    end else if (sck_rise && phase_last) begin
      case (state_q)
        ST_CMD: begin
          if (in_byte == OP_SET_BURST) begin
            state_d = ST_BLEN;
          end else if (in_byte == OP_FAST_READ) begin
            state_d = ST_ADDR;
          end else if (in_byte == OP_WRAP_READ && quad_q) begin
            state_d = ST_ADDR;
          end else if ((in_byte == OP_QUAD_OUT_RD || in_byte == OP_QUAD_IO_RD)
                       && !quad_q && i_quad_io_enable_bit) begin
            state_d = ST_ADDR;
          end else begin
            state_d = ST_IGNORE;
          end
        end
        ST_ADDR:  state_d = has_mode ? ST_MODE : ST_DUMMY;
        ST_MODE:  state_d = ST_DUMMY;
        ST_DUMMY: state_d = ST_DATA;
        ST_BLEN:  state_d = ST_IGNORE;
        default:  state_d = state_q;
      endcase
    end
  end

  // Shift-in, command, mode flags and burst length
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q    <= ST_IDLE;
      cmd_q      <= OP_FAST_READ;
      sh_q       <= 32'h0;
      cnt_q      <= 5'd0;
      quad_q     <= 1'b0;
      cont_q     <= 1'b0;
      cont_txn_q <= 1'b0;
      ff_seen_q  <= 1'b0;
      burst_q    <= BURST_RST;
    end else begin
      state_q <= state_d;
      if (cs_rise) begin
        cnt_q <= 5'd0;
        // A continuous read cut short by FFH in the address slot
        if (cont_txn_q && state_q == ST_ADDR && ff_seen_q) begin
          cont_q <= 1'b0;
        end
      end else if (cs_fall) begin
        cnt_q      <= 5'd0;
        cont_txn_q <= cont_q;
        ff_seen_q  <= 1'b0;
      end else if (sck_rise) begin
        sh_q  <= sh_next;
        cnt_q <= phase_last ? 5'd0 : cnt_q + 5'd1;
        if (state_q == ST_ADDR && cnt_q == (addr_x4 ? 5'd1 : 5'd7)) begin
          ff_seen_q <= (in_byte == CONT_EXIT_BYTE);
        end
        if (phase_last) begin
          case (state_q)
            ST_CMD: begin
              cmd_q <= in_byte;
              if (in_byte == OP_QUAD_EXIT) begin
                quad_q <= 1'b0;
                cont_q <= 1'b0;
              end else if (in_byte == OP_QUAD_ENTRY) begin
                quad_q <= 1'b1;
              end
            end
            ST_MODE: cont_q <= (in_byte[7:4] == MODE_CONT_NIB);
            ST_BLEN: begin
              if (in_byte[7:2] == 6'h00) begin
                burst_q <= in_byte[1:0];
              end
            end
            default: begin
            end
          endcase
        end
      end
    end
  end

  // Array address and fetch enable; a byte taken as select rises still steps
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      addr_q  <= ADDR_RST;
      rd_en_q <= 1'b0;
    end else if (sck_rise && phase_last && state_q == ST_ADDR) begin
      addr_q  <= sh_next[ADDR_W-1:0];
      rd_en_q <= 1'b1;
    end else begin
      if (buf_push) begin
        addr_q <= next_addr(addr_q, wrap, burst_q);
      end
      if (cs_rise || cs_fall) begin
        rd_en_q <= 1'b0;
      end
    end
  end

  // Output serialiser on falling serial clock
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      out_q     <= 8'h00;
      out_cnt_q <= 3'd0;
      sio_out_q <= 4'h0;
      sio_oe_q  <= 4'h0;
    end else if (cs_b_s || state_q != ST_DATA) begin
      out_cnt_q <= 3'd0;
      sio_oe_q  <= 4'h0;
    end else if (sck_fall) begin
      sio_oe_q <= data_x4 ? 4'hf : 4'h2;
      if (out_cnt_q == 3'd0) begin
        out_q     <= data_x4 ? {pop_byte[3:0], 4'h0} : {pop_byte[6:0], 1'b0};
        out_cnt_q <= data_x4 ? 3'd1 : 3'd7;
        sio_out_q <= data_x4 ? pop_byte[7:4] : {2'b00, pop_byte[7], 1'b0};
      end else begin
        out_q     <= data_x4 ? {out_q[3:0], 4'h0} : {out_q[6:0], 1'b0};
        out_cnt_q <= out_cnt_q - 3'd1;
        sio_out_q <= data_x4 ? out_q[7:4] : {2'b00, out_q[7], 1'b0};
      end
    end
  end

  // Ready delay register and outputs; o_rd_ready is an AND of registered terms, not a register
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rd_ready_q <= 1'b0;
    end else begin
      rd_ready_q <= rd_en_q;
    end
  end

  assign o_serial_data_lines    = sio_out_q;
  assign o_serial_data_lines_oe = sio_oe_q;
  assign o_rd_addr              = addr_q;
  assign o_rd_en                = rd_en_q;
  assign o_rd_ready             = buf_in_ready & rd_ready_q & rd_en_q;
  assign o_quad_mode            = quad_q;
  assign o_cont_mode            = cont_q;
  assign o_burst_len            = burst_q;

endmodule // qsf_read_path

// *** test/qsf_host_model.sv ***
`timescale 1ns/100ps
module qsf_host_model (
  input  wire logic       i_clk,
  input  wire logic [3:0] i_lines,
  output logic            o_sck,
  output logic            o_cs_b,
  output logic [3:0]      o_drive
);
  // Idle link: select high, clock low
  initial begin
    o_sck = 1'b0;
    o_cs_b = 1'b1;
    o_drive = 4'ha;
  end
  // Step on falling bench clock edges
  task automatic waitn(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  // Open a frame
  task automatic start();
    o_cs_b <= 1'b0;
    waitn(4);
  endtask
  // Close a frame, hold select high past the synchroniser
  task automatic stop();
    o_cs_b <= 1'b1;
    waitn(8);
  endtask
  // Shift n clocks of v, most significant first
  task automatic shift(input logic [31:0] v, input int n, input bit quad);
    for (int i = n - 1; i >= 0; i--) begin
      if (quad) o_drive <= v[4*i +: 4];
      else o_drive <= {3'b101, v[i]};
      waitn(4);
      o_sck <= 1'b1;
      waitn(4);
      o_sck <= 1'b0;
    end
  endtask
  // Clock one byte out, sampling late in the high phase
  task automatic rd(output logic [7:0] b, input bit quad);
    for (int i = 0; i < (quad ? 2 : 8); i++) begin
      o_drive <= ~o_drive; // Released lines keep moving
      waitn(4);
      o_sck <= 1'b1;
      waitn(3);
      b = quad ? {b[3:0], i_lines} : {b[6:0], i_lines[1]};
      waitn(1);
      o_sck <= 1'b0;
    end
  endtask
endmodule // qsf_host_model

// *** test/qsf_read_path_assertions.sv ***
`timescale 1ns/100ps
module qsf_read_path_assertions
  import qsf_pkg::*;
(
  input wire logic               i_clk,
  input wire logic               i_rst_b,
  input wire logic               i_sck,
  input wire logic               i_cs_b,
  input wire logic [3:0]         i_serial_data_lines,
  input wire logic [3:0]         o_serial_data_lines,
  input wire logic [3:0]         o_serial_data_lines_oe,
  input wire logic               i_quad_io_enable_bit,
  input wire logic [ADDR_W-1:0]  o_rd_addr,
  input wire logic               o_rd_en,
  input wire logic               i_rd_valid,
  input wire logic [7:0]         i_rd_data,
  input wire logic               i_rd_locked,
  input wire logic               o_rd_ready,
  input wire logic               o_quad_mode,
  input wire logic               o_cont_mode,
  input wire logic [BURST_W-1:0] o_burst_len
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  // Array accept and select release
  sequence s_acc;
    i_rd_valid && o_rd_ready;
  endsequence
  sequence s_cs_up;
    $rose(i_cs_b);
  endsequence
  // Mode state and link drive
  reset_vals_a: assert property ($rose(i_rst_b) |-> !o_quad_mode && !o_cont_mode
    && o_burst_len == BURST_RST) else $error("mode bits not idle after reset");
  oe_release_a: assert property (s_cs_up |-> ##[1:5] (o_serial_data_lines_oe == 4'h0))
    else $error("lines still driven after select rose");
  rd_stop_a: assert property (s_cs_up |-> ##[1:5] !o_rd_en)
    else $error("array reads continue after select rose");
  quiet_idle_a: assert property (i_cs_b [*6] |-> o_serial_data_lines_oe == 4'h0 && !o_rd_en)
    else $error("activity while deselected");
  oe_shape_a: assert property (o_serial_data_lines_oe inside {4'h0, 4'h2, 4'hf})
    else $error("illegal line enable pattern");
  // Array port handshake
  addr_step_a: assert property (s_acc |=> o_rd_addr != $past(o_rd_addr))
    else $error("address did not advance after accept");
  addr_hold_a: assert property ((o_rd_en && !(i_rd_valid && o_rd_ready)) ##1 o_rd_en
    |-> $stable(o_rd_addr)) else $error("address moved without accept");
  ready_en_a: assert property (o_rd_ready |-> o_rd_en)
    else $error("ready outside a read");
  buf_depth_a: assert property (not (s_acc [*4]))
    else $error("buffer took more bytes than it holds");
endmodule // qsf_read_path_assertions

bind qsf_read_path qsf_read_path_assertions qsf_read_path_assertions_inst (
  .i_clk, .i_rst_b, .i_sck, .i_cs_b, .i_serial_data_lines, .o_serial_data_lines,
  .o_serial_data_lines_oe, .i_quad_io_enable_bit, .o_rd_addr, .o_rd_en, .i_rd_valid,
  .i_rd_data, .i_rd_locked, .o_rd_ready, .o_quad_mode, .o_cont_mode, .o_burst_len
);

// *** test/qsf_read_path_tb_top.sv ***
`timescale 1ns/100ps
module qsf_read_path_tb_top
  import qsf_pkg::*;
;
  logic clk, rst_b, qen;
  logic sck, cs_b, rd_en, rd_ready, quad, cont;
  logic tick = 1'b0, rd_valid = 1'b0, rd_locked = 1'b0;
  logic [7:0] rd_data = 8'h00;
  logic [3:0] host_d, dev_d, dev_oe, lines;
  logic [23:0] rd_addr;
  logic [1:0] blen;
  int n_fail = 0, comparisons = 0;
  // Wire level from the device's enables; the host drives every other line
  assign lines = (dev_oe & dev_d) | (~dev_oe & host_d);
  qsf_read_path qsf_read_path_inst (.i_clk(clk), .i_rst_b(rst_b), .i_sck(sck), .i_cs_b(cs_b),
    .i_serial_data_lines(lines), .o_serial_data_lines(dev_d), .o_serial_data_lines_oe(dev_oe),
    .i_quad_io_enable_bit(qen), .o_rd_addr(rd_addr), .o_rd_en(rd_en), .i_rd_valid(rd_valid),
    .i_rd_data(rd_data), .i_rd_locked(rd_locked), .o_rd_ready(rd_ready), .o_quad_mode(quad),
    .o_cont_mode(cont), .o_burst_len(blen));
  qsf_host_model qsf_host_model_inst (.i_clk(clk), .i_lines(lines), .o_sck(sck),
    .o_cs_b(cs_b), .o_drive(host_d));
  function automatic logic [7:0] mem(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction
  // Array model, stalling every other cycle
  always @(negedge clk) begin
    tick <= ~tick;
    rd_valid <= rd_en & tick;
    rd_data <= mem(rd_addr);
    rd_locked <= rd_addr[23:16] == 8'h80;
  end
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Short command frame with optional data cycle
  task automatic cmd(input logic [7:0] op, input int ocl, input logic [7:0] d, input int dcl);
    qsf_host_model_inst.start();
    qsf_host_model_inst.shift(op, ocl, ocl == 2);
    qsf_host_model_inst.shift(d, dcl, ocl == 2);
    qsf_host_model_inst.stop();
  endtask
  // Full read frame, bytes compared against the array model
  task automatic rd_frame(input string what, input logic [7:0] op, input int ocl,
      input logic [23:0] a, input bit aq, input int mcl, input logic [7:0] md, input int dcl,
      input bit dq, input int n, input logic [23:0] m);
    logic [7:0] b;
    qsf_host_model_inst.start();
    qsf_host_model_inst.shift(op, ocl, ocl == 2);
    qsf_host_model_inst.shift(a, aq ? 6 : 24, aq);
    qsf_host_model_inst.shift(md, mcl, 1'b1);
    qsf_host_model_inst.shift(32'h0, dcl, aq);
    check("buffer full", rd_ready, 24'h0);
    for (int i = 0; i < n; i++) begin
      qsf_host_model_inst.rd(b, dq);
      check(what, b, (a[23:16] == 8'h80) ? 8'h00 : mem(a));
      a = (a & ~m) | ((a + 24'h1) & m);
    end
    qsf_host_model_inst.stop();
  endtask
  task automatic t_reset();
    check("quad mode", quad, 24'h0);
    check("cont mode", cont, 24'h0);
    check("burst", blen, BURST_RST);
  endtask
  task automatic t_single();
    rd_frame("x1 roll", OP_FAST_READ, 8, 24'hfffffe, 0, 0, 0, 8, 0, 3, 24'hffffff);
    rd_frame("x1 lock", OP_FAST_READ, 8, 24'h80ffff, 0, 0, 0, 8, 0, 2, 24'hffffff);
  endtask
  task automatic t_refused();
    logic [7:0] b;
    qen <= 1'b0;
    qsf_host_model_inst.start();
    qsf_host_model_inst.shift(OP_QUAD_OUT_RD, 8, 0);
    qsf_host_model_inst.shift(32'h0, 32, 0);
    qsf_host_model_inst.rd(b, 1);
    check("refused oe", dev_oe, 24'h0);
    qsf_host_model_inst.stop();
    qen <= 1'b1;
  endtask
  task automatic t_quad_reads();
    rd_frame("x4 out", OP_QUAD_OUT_RD, 8, 24'h000123, 0, 0, 0, 8, 1, 3, 24'hffffff);
    rd_frame("qio", OP_QUAD_IO_RD, 8, 24'h001000, 1, 2, 8'ha5, 4, 1, 2, 24'hffffff);
    check("qio cont", cont, 24'h1);
    rd_frame("qio next", 8'h00, 0, 24'h00abcd, 1, 2, 8'h00, 4, 1, 2, 24'hffffff);
    check("cont end", cont, 24'h0);
  endtask
  task automatic t_burst();
    for (int c = 0; c < 4; c++) begin
      cmd(OP_SET_BURST, 8, c[7:0], 8);
      check("burst code", blen, c[23:0]);
    end
    cmd(OP_SET_BURST, 8, 8'h13, 8);
    check("burst kept", blen, 24'h3);
  endtask
  task automatic t_quad_mode();
    cmd(OP_QUAD_ENTRY, 8, 8'h00, 0);
    check("quad on", quad, 24'h1);
    cmd(OP_SET_BURST, 2, 8'h01, 2);
    check("x4 burst", blen, 24'h1);
    rd_frame("wrap", OP_WRAP_READ, 2, 24'h00011e, 1, 0, 0, 6, 1, 4, 24'h00000f);
    rd_frame("x4 read", OP_FAST_READ, 2, 24'hfffffe, 1, 2, 8'ha0, 4, 1, 3, 24'hffffff);
    check("x4 cont", cont, 24'h1);
    cmd(OP_QUAD_EXIT, 2, 8'h00, 0);
    check("first exit cont", cont, 24'h0);
    check("first exit quad", quad, 24'h1);
    cmd(OP_QUAD_EXIT, 2, 8'h00, 0);
    check("second exit", quad, 24'h0);
  endtask
  // Bench clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Hang limit
  initial begin
    repeat (90000) @(posedge clk);
    n_fail++;
    complete_run();
  end
  initial begin
    rst_b = 1'b0;
    qen = 1'b1;
    repeat (2) @(negedge clk);
    rst_b <= 1'b1;
    repeat (4) @(negedge clk);
    t_reset();
    t_single();
    t_refused();
    t_quad_reads();
    t_burst();
    t_quad_mode();
    complete_run();
  end
endmodule // qsf_read_path_tb_top
